// file: rtl/dcc_controller.sv
// debug command controller: serial command/data chains, decoder, status/control
// assumes the JTAG pins and tap signals are asynchronous and are sampled here;
// the core side signals are on clock_in
//
// Operation
// - commands are shifted serially from test data input into an 8-bit register
// - select codes 0-2, 5 and 6 pick status, counter, control and limit registers
// - codes 9 to 0xd pick bus captures, instruction latch, goto, step counter
// - codes 0xf-0x11 read stage addresses; 0x12 reads history and advances
// - exit bit resumes normal operation only together with a legal execute
// - execute bit runs the latched instruction, then returns unless exiting
// - execute acts only on program bus write or any no-register access
// - bit 7 zero writes following data, one reads register out
// - decoder uses command, update indication and halted state to make strobes
// - status/control is 24 bits, cleared by hardware reset
// - status bit 0 enables trace mode
// - status bit 1 turns breakpoint, step and software entry into vectored interrupt at offset 6
// - bit 2 marks entry by software break, cleared on leaving debug
// - bit 3 marks entry by memory breakpoint, cleared on leaving debug
// - bit 4 marks entry by step counter zero in trace mode
// - status bit 5 and bits 8-23 read zero
// - bits 6-7 report running, wait/stop, bus wait or debug
// - core state bits are also offered to the instruction register
// - breakpoint logic compares accesses with limits and counts events
// - registers reachable only after the debug access instruction is loaded
`timescale 1ns/10ps
module dcc_controller
	import dcc_pkg::*;
(
	input  wire logic                 clock_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 tck_in,
	input  wire logic                 tdi_in,
	input  wire logic                 shift_dr_in,
	input  wire logic                 update_dr_in,
	input  wire logic                 debug_access_instruction_in,
	input  wire logic                 debug_event_line_n_in,
	output logic                      debug_event_line_n_out,
	output logic                      debug_event_line_n_oe_out,
	output logic                      tdo_out,
	input  dcc_pkg::dcc_core_t        core_in,
	input  dcc_pkg::dcc_access_t      access_in,
	input  wire logic [REG_W-1:0]     instruction_latch_in,
	input  wire logic [REG_W-1:0]     global_bus_in,
	input  wire logic                 global_bus_load_in,
	input  wire logic [REG_W-1:0]     fetch_address_in,
	input  wire logic [REG_W-1:0]     decode_address_in,
	input  wire logic [REG_W-1:0]     execute_address_in,
	input  wire logic [REG_W-1:0]     flow_history_in,
	output dcc_pkg::dcc_strobe_t      strobe_out,
	output logic                      flow_history_advance_out,
	output logic [REG_W-1:0]          program_bus_out,
	output logic [REG_W-1:0]          goto_address_out,
	output logic                      goto_valid_out,
	output logic                      execute_go_out,
	output logic                      exit_debug_out,
	output logic                      debug_request_out,
	output logic                      vector_interrupt_out,
	output logic [7:0]                vector_offset_out,
	output logic                      trace_enable_out,
	output logic [1:0]                core_state_out
);
	import dcc_pkg::*;

	typedef enum logic [1:0] {PH_CMD, PH_DATA} dcc_phase_t;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic              tck_prev;
		logic              upd_prev;
		dcc_phase_t        phase;
		logic [CMD_W-1:0]  cmd_sr;
		dcc_cmd_t          cmd;
		logic [DATA_W-1:0] data_sr;
		logic [STAT_W-1:0] status;
		logic [BPC_W-1:0]  bp_ctl;
		logic [REG_W-1:0]  limit0;
		logic [REG_W-1:0]  limit1;
		logic [REG_W-1:0]  gdb;
		logic [REG_W-1:0]  pdb;
		logic [REG_W-1:0]  goto_addr;
		logic              goto_valid;
		logic [REG_W-1:0]  step;
		logic              halted_prev;
		logic              bp_pend;
		logic              step_pend;
		dcc_strobe_t       strobe;
		logic              hist_adv;
		logic              go;
		logic              ex;
		logic              vec_int;
	} dcc_state_t;

	dcc_state_t state;
	dcc_state_t next_state;

	logic [REG_W-1:0] bp_count;
	logic             bp_hit;
	logic             bp_count_wr;

	// reserved codes answer like an absent register
	function automatic logic sel_valid(input logic [4:0] sel);
		unique case (sel)
			SEL_STATUS, SEL_BP_CNT, SEL_BP_CTL, SEL_LIMIT0, SEL_LIMIT1, SEL_GDB, SEL_PDB,
			SEL_PIL, SEL_GOTO, SEL_STEP, SEL_FETCH, SEL_DECODE, SEL_EXECUTE,
			SEL_HISTORY: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// execute and exit are honoured only on these accesses
	function automatic logic go_legal(input dcc_cmd_t c);
		return (c.sel == SEL_PDB && !c.rd) || c.sel == SEL_NONE;
	endfunction

	// a 16-bit write arrives in the top of the 24-bit chain
	function automatic logic [REG_W-1:0] word_of(input logic [DATA_W-1:0] sr);
		return sr[DATA_W-1:DATA_W-REG_W];
	endfunction

	logic              tck_rise;
	logic              upd_rise;
	logic              tdi_s;
	logic              shift_s;
	logic              access_s;
	logic              de_req_s;
	logic [1:0]        core_state;
	logic [DATA_W-1:0] status_word;
	logic [REG_W-1:0]  read_word;
	logic              entry_now;
	logic              leave_now;
	logic [REG_W-1:0]  wdata;

	always_comb
	begin
		next_state = state;
		next_state.sync1 = {tck_in, tdi_in, shift_dr_in, update_dr_in,
			debug_access_instruction_in, ~debug_event_line_n_in};
		next_state.sync2 = state.sync1;
		next_state.tck_prev = state.sync2[5];
		next_state.upd_prev = state.sync2[2];
		tdi_s = state.sync2[4];
		shift_s = state.sync2[3];
		access_s = state.sync2[1];
		de_req_s = state.sync2[0];
		tck_rise = state.sync2[5] & ~state.tck_prev;
		upd_rise = state.sync2[2] & ~state.upd_prev;
		next_state.strobe = '0;
		next_state.hist_adv = 1'b0;
		next_state.go = 1'b0;
		next_state.ex = 1'b0;
		next_state.vec_int = 1'b0;
		next_state.goto_valid = 1'b0;
		bp_count_wr = 1'b0;
		wdata = word_of(state.data_sr);

		if (core_in.halted)
			core_state = CORE_DBG;
		else if (core_in.bus_wait)
			core_state = CORE_BUS;
		else if (core_in.wait_stop)
			core_state = CORE_WAIT;
		else
			core_state = CORE_RUN;

		status_word = '0;
		status_word[ST_STEP_FLAG:ST_TRACE_EN] = state.status[ST_STEP_FLAG:ST_TRACE_EN];
		status_word[ST_CORE_LO+1:ST_CORE_LO] = core_state;

		unique case (state.cmd.sel)
			SEL_BP_CNT:  read_word = bp_count;
			SEL_BP_CTL:  read_word = {4'h0, state.bp_ctl};
			SEL_LIMIT0:  read_word = state.limit0;
			SEL_LIMIT1:  read_word = state.limit1;
			SEL_GDB:     read_word = state.gdb;
			SEL_PDB:     read_word = state.pdb;
			SEL_PIL:     read_word = instruction_latch_in;
			SEL_STEP:    read_word = state.step;
			SEL_FETCH:   read_word = fetch_address_in;
			SEL_DECODE:  read_word = decode_address_in;
			SEL_EXECUTE: read_word = execute_address_in;
			SEL_HISTORY: read_word = flow_history_in;
			default:     read_word = REG_RST;
		endcase

		// serial chains move only while the access instruction is loaded
		if (access_s && shift_s && tck_rise)
		begin
			if (state.phase == PH_CMD)
				next_state.cmd_sr = {tdi_s, state.cmd_sr[CMD_W-1:1]};
			else
				next_state.data_sr = {tdi_s, state.data_sr[DATA_W-1:1]};
		end

		if (access_s && upd_rise)
		begin
			unique case (state.phase)
				PH_CMD:
				begin
					next_state.cmd = dcc_cmd_t'(state.cmd_sr);
					next_state.strobe.sel = state.cmd_sr[4:0];
					if (state.cmd_sr[4:0] == SEL_NONE)
					begin
						// no data follows a no-register command
						next_state.go = state.cmd_sr[6] & core_in.halted;
						next_state.ex = state.cmd_sr[6] & state.cmd_sr[5] &
							core_in.halted;
					end
					else
					begin
						next_state.phase = PH_DATA;
						next_state.data_sr = '0;
						if (state.cmd_sr[7])
						begin
							next_state.strobe.rd = sel_valid(state.cmd_sr[4:0]);
							next_state.hist_adv = state.cmd_sr[4:0] == SEL_HISTORY;
						end
					end
				end
				PH_DATA:
				begin
					next_state.phase = PH_CMD;
					if (!state.cmd.rd && sel_valid(state.cmd.sel))
					begin
						next_state.strobe.wr = 1'b1;
						next_state.strobe.sel = state.cmd.sel;
						unique case (state.cmd.sel)
							SEL_STATUS:
								next_state.status[ST_INT_MODE:ST_TRACE_EN] =
									state.data_sr[ST_INT_MODE:ST_TRACE_EN];
							SEL_BP_CNT: bp_count_wr = 1'b1;
							SEL_BP_CTL: next_state.bp_ctl = wdata[BPC_W-1:0];
							SEL_LIMIT0: next_state.limit0 = wdata;
							SEL_LIMIT1: next_state.limit1 = wdata;
							SEL_GDB:    next_state.gdb = wdata;
							SEL_PDB:    next_state.pdb = wdata;
							SEL_GOTO:
							begin
								next_state.goto_addr = wdata;
								next_state.goto_valid = 1'b1;
							end
							SEL_STEP:   next_state.step = wdata;
							default:    next_state.strobe.wr = 1'b0;
						endcase
					end
					if (go_legal(state.cmd) && core_in.halted)
					begin
						next_state.go = state.cmd.go;
						next_state.ex = state.cmd.go & state.cmd.ex;
					end
				end
				default: next_state.phase = PH_CMD;
			endcase
		end

		// read data is loaded one cycle after the command takes effect
		if (state.strobe.rd)
			next_state.data_sr = (state.cmd.sel == SEL_STATUS) ? status_word :
				{8'h00, read_word};

		if (global_bus_load_in)
			next_state.gdb = global_bus_in;

		// step counter runs only while the core executes in trace mode
		if (state.status[ST_TRACE_EN] && !core_in.halted && core_in.instr_done &&
				state.step != REG_RST)
			next_state.step = state.step - 16'h0001;

		entry_now = core_in.halted & ~state.halted_prev;
		leave_now = ~core_in.halted & state.halted_prev;
		next_state.halted_prev = core_in.halted;

		// pending causes: a new hit wins over the clear at entry
		next_state.bp_pend = (state.bp_pend & ~entry_now) | bp_hit;
		next_state.step_pend = (state.step_pend & ~entry_now) |
			(state.status[ST_TRACE_EN] && !core_in.halted && core_in.instr_done &&
			state.step == 16'h0001);
		if (state.status[ST_INT_MODE] &&
				(state.bp_pend || state.step_pend || core_in.sw_entry))
		begin
			next_state.vec_int = 1'b1;
			next_state.bp_pend = bp_hit;
			next_state.step_pend = 1'b0;
		end

		if (entry_now)
		begin
			next_state.status[ST_SW_FLAG] = core_in.sw_entry;
			next_state.status[ST_BP_FLAG] = state.bp_pend;
			next_state.status[ST_STEP_FLAG] = state.step_pend;
		end
		else if (leave_now)
			next_state.status[ST_STEP_FLAG:ST_SW_FLAG] = 3'h0;
		next_state.status[STAT_W-1:ST_STEP_FLAG+1] = '0;
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			state <= '0;
			state.phase <= PH_CMD;
			state.status <= STATUS_RST;
		end
		else
			state <= next_state;
	end

	dcc_breakpoint u_breakpoint (
		.clock_in      (clock_in),
		.rst_n_in      (rst_n_in),
		.control_in    (state.bp_ctl),
		.limit0_in     (state.limit0),
		.limit1_in     (state.limit1),
		.access_in     (access_in),
		.count_wr_in   (bp_count_wr),
		.count_data_in (wdata),
		.count_out     (bp_count),
		.hit_out       (bp_hit)
	);

	assign tdo_out = state.data_sr[0];
	assign strobe_out = state.strobe;
	assign flow_history_advance_out = state.hist_adv;
	assign program_bus_out = state.pdb;
	assign goto_address_out = state.goto_addr;
	assign goto_valid_out = state.goto_valid;
	assign execute_go_out = state.go;
	assign exit_debug_out = state.ex;
	// interrupt mode suppresses the halt request entirely
	assign debug_request_out = ~state.status[ST_INT_MODE] &
		(state.bp_pend | state.step_pend | de_req_s);
	assign vector_interrupt_out = state.vec_int;
	assign vector_offset_out = VECTOR_OFFSET;
	assign trace_enable_out = state.status[ST_TRACE_EN];
	assign core_state_out = state.halted_prev ? CORE_DBG :
		status_word[ST_CORE_LO+1:ST_CORE_LO];
	// open drain acknowledge: pull low while halted
	assign debug_event_line_n_out = 1'b0;
	assign debug_event_line_n_oe_out = core_in.halted;
endmodule // dcc_controller

// file: rtl/dcc_pkg.sv
// debug command controller: shared constants, select codes and carrier types
// assumes one system clock; all link pins are sampled by that clock
package dcc_pkg;
	localparam int CMD_W   = 8;
	localparam int DATA_W  = 24;
	localparam int REG_W   = 16;
	localparam int STAT_W  = 8;
	localparam int SYNC_W  = 6;
	localparam int BPC_W   = 12;

	// register select codes
	localparam logic [4:0] SEL_STATUS  = 5'h00;
	localparam logic [4:0] SEL_BP_CNT  = 5'h01;
	localparam logic [4:0] SEL_BP_CTL  = 5'h02;
	localparam logic [4:0] SEL_LIMIT0  = 5'h05;
	localparam logic [4:0] SEL_LIMIT1  = 5'h06;
	localparam logic [4:0] SEL_GDB     = 5'h09;
	localparam logic [4:0] SEL_PDB     = 5'h0a;
	localparam logic [4:0] SEL_PIL     = 5'h0b;
	localparam logic [4:0] SEL_GOTO    = 5'h0c;
	localparam logic [4:0] SEL_STEP    = 5'h0d;
	localparam logic [4:0] SEL_FETCH   = 5'h0f;
	localparam logic [4:0] SEL_DECODE  = 5'h10;
	localparam logic [4:0] SEL_EXECUTE = 5'h11;
	localparam logic [4:0] SEL_HISTORY = 5'h12;
	localparam logic [4:0] SEL_NONE    = 5'h1f;

	// status/control bit positions
	localparam int ST_TRACE_EN  = 0;
	localparam int ST_INT_MODE  = 1;
	localparam int ST_SW_FLAG   = 2;
	localparam int ST_BP_FLAG   = 3;
	localparam int ST_STEP_FLAG = 4;
	localparam int ST_CORE_LO   = 6;

	// core state encodings
	localparam logic [1:0] CORE_RUN  = 2'h0;
	localparam logic [1:0] CORE_WAIT = 2'h1;
	localparam logic [1:0] CORE_BUS  = 2'h2;
	localparam logic [1:0] CORE_DBG  = 2'h3;

	localparam logic [7:0] VECTOR_OFFSET = 8'h06;

	// reset values
	localparam logic [STAT_W-1:0] STATUS_RST = 8'h00;
	localparam logic [REG_W-1:0]  REG_RST    = 16'h0000;

	typedef struct packed {
		logic       rd;
		logic       go;
		logic       ex;
		logic [4:0] sel;
	} dcc_cmd_t;

	typedef struct packed {
		logic halted;
		logic wait_stop;
		logic bus_wait;
		logic sw_entry;
		logic instr_done;
	} dcc_core_t;

	typedef struct packed {
		logic             valid;
		logic [1:0]       space;
		logic             rd;
		logic             wr;
		logic [REG_W-1:0] addr;
	} dcc_access_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] sel;
	} dcc_strobe_t;
endpackage

// file: rtl/dcc_breakpoint.sv
// memory breakpoint unit: address latch, two limit comparators, event counter
// assumes access records come from logic on the same clock
`timescale 1ns/10ps
module dcc_breakpoint
	import dcc_pkg::*;
(
	input  wire logic                clock_in,
	input  wire logic                rst_n_in,
	input  wire logic [BPC_W-1:0]    control_in,
	input  wire logic [REG_W-1:0]    limit0_in,
	input  wire logic [REG_W-1:0]    limit1_in,
	input  dcc_pkg::dcc_access_t     access_in,
	input  wire logic                count_wr_in,
	input  wire logic [REG_W-1:0]    count_data_in,
	output logic      [REG_W-1:0]    count_out,
	output logic                     hit_out
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [REG_W-1:0] addr;
		logic             m0;
		logic             m1;
		logic             armed;
		logic [REG_W-1:0] count;
		logic             hit;
	} dcc_bp_state_t;

	dcc_bp_state_t state;
	dcc_bp_state_t next_state;

	function automatic logic compare(input logic [1:0] rw, input logic [1:0] cc,
			input dcc_access_t a, input logic [REG_W-1:0] lim);
		logic dir;
		logic cond;
		dir = (rw[0] & a.wr) | (rw[1] & a.rd);
		unique case (cc)
			2'h0: cond = a.addr != lim;
			2'h1: cond = a.addr == lim;
			2'h2: cond = a.addr < lim;
			2'h3: cond = a.addr > lim;
		endcase
		return dir & cond;
	endfunction

	logic space_ok;
	logic event_now;

	always_comb
	begin
		next_state = state;
		next_state.hit = 1'b0;
		space_ok = access_in.valid && control_in[1:0] != 2'h0 &&
			access_in.space == control_in[1:0];
		// compare the live access now and register the match alongside the address latch
		next_state.addr = access_in.addr;
		next_state.m0 = space_ok && compare(control_in[3:2], control_in[5:4], access_in,
			limit0_in);
		next_state.m1 = space_ok && compare(control_in[7:6], control_in[9:8], access_in,
			limit1_in);
		event_now = 1'b0;
		unique case (control_in[11:10])
			2'h0: event_now = state.m0 & state.m1;
			2'h1: event_now = state.m0 | state.m1;
			2'h2:
			begin
				event_now = state.armed & state.m1;
				if (state.m0)
					next_state.armed = 1'b1;
			end
			2'h3:
			begin
				event_now = state.armed & state.m0;
				if (state.m1)
					next_state.armed = 1'b1;
			end
		endcase
		if (event_now)
		begin
			if (state.count == REG_RST)
				next_state.hit = 1'b1;
			else
				next_state.count = state.count - 16'h0001;
		end
		// a counter write restarts the event sequence
		if (count_wr_in)
		begin
			next_state.count = count_data_in;
			next_state.armed = 1'b0;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
			state <= '0;
		else
			state <= next_state;
	end

	assign count_out = state.count;
	assign hit_out = state.hit;
endmodule // dcc_breakpoint

// file: verification/dcc_controller_asserts.sv
// checker: port timing of the debug command controller
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module dcc_controller_asserts
	import dcc_pkg::*;
(
	input  wire logic           clock_in,
	input  wire logic           rst_n_in,
	input  wire logic           debug_access_instruction_in,
	input  dcc_pkg::dcc_core_t  core_in,
	input  wire logic           debug_event_line_n_out,
	input  wire logic           debug_event_line_n_oe_out,
	input  dcc_pkg::dcc_strobe_t strobe_out,
	input  wire logic           flow_history_advance_out,
	input  wire logic           goto_valid_out,
	input  wire logic           execute_go_out,
	input  wire logic           exit_debug_out,
	input  wire logic [7:0]     vector_offset_out,
	input  wire logic           trace_enable_out,
	input  wire logic [1:0]     core_state_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// cycles since debug access was withdrawn; covers the pin synchronisers
	logic [3:0] idle_cnt;
	logic [3:0] next_idle_cnt;
	always_comb
	begin
		next_idle_cnt = idle_cnt;
		if (debug_access_instruction_in)
			next_idle_cnt = 4'h0;
		else if (idle_cnt != 4'hf)
			next_idle_cnt = idle_cnt + 4'h1;
	end
	always_ff @(posedge clock_in)
		idle_cnt <= rst_n_in ? next_idle_cnt : 4'h0;

	chk_strobe_single: assert property (strobe_out.wr |=> !strobe_out.wr)
		else $error("write strobe longer than one cycle");
	chk_rw_exclusive: assert property (!(strobe_out.wr && strobe_out.rd))
		else $error("read and write strobe together");
	chk_reserved_quiet: assert property ((strobe_out.wr || strobe_out.rd) |->
		!(strobe_out.sel inside {5'h03, 5'h04, 5'h07, 5'h08, 5'h0e, [5'h13:5'h1e]}))
		else $error("strobe on reserved code");
	chk_access_gate: assert property (idle_cnt >= 4'h8 |-> !strobe_out.wr && !strobe_out.rd)
		else $error("strobe without debug access");
	chk_halt_state: assert property (core_in.halted |-> core_state_out == CORE_DBG)
		else $error("core state not debug while halted");
	chk_halt_ack: assert property (debug_event_line_n_oe_out == core_in.halted
		&& !debug_event_line_n_out)
		else $error("event line acknowledge wrong");
	chk_history_step: assert property (flow_history_advance_out |->
		($past(strobe_out.rd) && $past(strobe_out.sel) == SEL_HISTORY)
		|| (strobe_out.rd && strobe_out.sel == SEL_HISTORY))
		else $error("history advance without its read");
	chk_goto_cause: assert property (goto_valid_out |->
		($past(strobe_out.wr) && $past(strobe_out.sel) == SEL_GOTO)
		|| (strobe_out.wr && strobe_out.sel == SEL_GOTO))
		else $error("goto valid without its write");
	chk_go_halted: assert property (execute_go_out |-> $past(core_in.halted))
		else $error("execute while running");
	chk_exit_paired: assert property (exit_debug_out |->
		(execute_go_out || $past(execute_go_out)) or (##1 execute_go_out))
		else $error("exit without execute");
	chk_vector_fixed: assert property (vector_offset_out == VECTOR_OFFSET)
		else $error("vector offset wrong");
	chk_reset_clear: assert property (!$past(rst_n_in) |-> !trace_enable_out && !strobe_out.wr)
		else $error("state not cleared by reset");
endmodule // dcc_controller_asserts

bind dcc_controller dcc_controller_asserts i_chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in),
	.debug_access_instruction_in(debug_access_instruction_in), .core_in(core_in),
	.debug_event_line_n_out(debug_event_line_n_out),
	.debug_event_line_n_oe_out(debug_event_line_n_oe_out), .strobe_out(strobe_out),
	.flow_history_advance_out(flow_history_advance_out), .goto_valid_out(goto_valid_out),
	.execute_go_out(execute_go_out), .exit_debug_out(exit_debug_out),
	.vector_offset_out(vector_offset_out), .trace_enable_out(trace_enable_out),
	.core_state_out(core_state_out)
);

// file: verification/dcc_jtag_host.sv
// partner model: external debug probe driving the serial link pins
// assumes the bench clock; the link clock stands still between frames
`timescale 1ns/10ps
module dcc_jtag_host (
	input  wire logic clock_in,
	input  wire logic tdo_in,
	output logic      tck_out,
	output logic      tdi_out,
	output logic      shift_out,
	output logic      update_out,
	output logic      event_n_oe_out
);
	initial
	begin
		tck_out = 1'b0;
		tdi_out = 1'b0;
		shift_out = 1'b0;
		update_out = 1'b0;
		event_n_oe_out = 1'b0;
	end
	// debug entry request on the open-drain event line
	task automatic request(input logic on);
		event_n_oe_out <= on;
	endtask
	// half of the 80 ns link period
	task automatic half();
		repeat (10) @(posedge clock_in);
	endtask
	// n bits lsb first, then an update; tdo taken just before each rise
	task automatic frame(input logic [23:0] dout, input int n, output logic [23:0] din);
		din = '0;
		shift_out <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			tdi_out <= dout[i];
			half();
			din[i] = tdo_in;
			tck_out <= 1'b1;
			half();
			tck_out <= 1'b0;
		end
		shift_out <= 1'b0;
		// released data line must not keep showing the last bit
		tdi_out <= ~tdi_out;
		update_out <= 1'b1;
		half();
		update_out <= 1'b0;
		half();
	endtask
endmodule // dcc_jtag_host

// file: verification/tb_top.sv
// bench top: controller driven through the probe model, checked against a shadow model
// assumes a 250 MHz system clock and an 80 ns link clock
`timescale 1ns/10ps
module tb_top;
	import dcc_pkg::*;
	logic        clock_in, rst_n_in, acc, lo, oe, tdo, tck, tdi, sh, up, p_oe;
	logic        adv, go, ex, gv, vi, te, dr;
	logic [15:0] il, fa, da, xa, fh, pb, ga;
	logic [7:0]  vo;
	logic [1:0]  cs;
	logic [23:0] v;
	dcc_core_t   core;
	dcc_strobe_t stb;
	dcc_access_t mem;
	int          fails, checks, n_go, n_ex, n_adv, n_gv, n_vi;
	int          shadow[32];
	logic [4:0]  rw[7] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0d};
	logic [4:0]  res[8] = '{5'h03, 5'h04, 5'h07, 5'h08, 5'h0e, 5'h13, 5'h14, 5'h18};
	wire         line_n = !((oe && !lo) || p_oe);

	dcc_jtag_host host (.clock_in(clock_in), .tdo_in(tdo), .tck_out(tck), .tdi_out(tdi),
		.shift_out(sh), .update_out(up), .event_n_oe_out(p_oe));
	dcc_controller i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .tck_in(tck),
		.tdi_in(tdi), .shift_dr_in(sh), .update_dr_in(up),
		.debug_access_instruction_in(acc), .debug_event_line_n_in(line_n),
		.debug_event_line_n_out(lo), .debug_event_line_n_oe_out(oe), .tdo_out(tdo),
		.core_in(core), .access_in(mem), .instruction_latch_in(il), .global_bus_in(16'h0),
		.global_bus_load_in(1'b0), .fetch_address_in(fa), .decode_address_in(da),
		.execute_address_in(xa), .flow_history_in(fh), .strobe_out(stb),
		.flow_history_advance_out(adv), .program_bus_out(pb), .goto_address_out(ga),
		.goto_valid_out(gv), .execute_go_out(go), .exit_debug_out(ex),
		.debug_request_out(dr), .vector_interrupt_out(vi), .vector_offset_out(vo),
		.trace_enable_out(te), .core_state_out(cs));

	initial
	begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	always @(posedge clock_in)
	begin
		n_go += go;
		n_ex += ex;
		n_adv += adv;
		n_gv += gv;
		n_vi += vi;
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string w);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t %s: saw %h want %h", $time, w, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [23:0] d);
		logic [23:0] x;
		host.frame({16'h0, cmd}, 8, x);
		if (cmd[4:0] != SEL_NONE)
			host.frame(d, cmd[4:0] == SEL_STATUS ? 24 : 16, x);
	endtask
	task automatic rd(input logic [4:0] sel, input logic [23:0] e, input string w);
		logic [23:0] x;
		host.frame({16'h0, 3'h4, sel}, 8, x);
		host.frame(24'h0, sel == SEL_STATUS ? 24 : 16, x);
		chk(x, e, w);
	endtask
	// drive on an edge; the #1 lets the caller look at settled outputs
	task automatic core_set(input logic [4:0] c);
		@(posedge clock_in);
		core <= c;
		#1;
	endtask

	initial
	begin
		repeat (90000) @(posedge clock_in);
		fails++;
		finish_test();
	end

	initial
	begin
		void'($urandom(38074));
		rst_n_in = 1'b0;
		acc = 1'b0;
		core = '0;
		mem = '0;
		{il, fa, da} = {$urandom, $urandom};
		{xa, fh} = $urandom;
		repeat (3) @(posedge clock_in);
		rst_n_in <= 1'b1;
		acc <= 1'b1;
		repeat (4) @(posedge clock_in);
		rd(SEL_STATUS, 24'h0, "status reset");
		chk(cs, CORE_RUN, "core run");
		host.request(1'b1);
		repeat (6) @(posedge clock_in);
		chk(dr, 1'b1, "event line request");
		host.request(1'b0);
		repeat (6) @(posedge clock_in);
		chk(dr, 1'b0, "event line released");
		$display("reset test done");
		foreach (rw[i])
		begin
			v = $urandom;
			shadow[rw[i]] = v[15:0] & (rw[i] == SEL_BP_CTL ? 16'h0fff : 16'hffff);
			wr({3'h0, rw[i]}, v);
			if (rw[i] == SEL_PDB)
				chk(pb, v[15:0], "program bus out");
		end
		foreach (res[i])
			wr({3'h0, res[i]}, 24'hffffff);
		foreach (rw[i])
			rd(rw[i], shadow[rw[i]], "readback");
		foreach (res[i])
			rd(res[i], 24'h0, "reserved read");
		rd(SEL_PIL, il, "latch");
		rd(SEL_FETCH, fa, "fetch");
		rd(SEL_DECODE, da, "decode");
		rd(SEL_EXECUTE, xa, "execute");
		rd(SEL_HISTORY, fh, "history");
		chk(n_adv, 1, "history advance");
		wr({3'h0, SEL_GOTO}, 24'h00a5c3);
		chk(ga, 16'ha5c3, "goto address");
		chk(n_gv, 1, "goto pulse");
		$display("register test done");
		acc <= 1'b0;
		wr({3'h0, SEL_LIMIT0}, ~shadow[5]);
		acc <= 1'b1;
		rd(SEL_LIMIT0, shadow[5], "access gate");
		wr({3'h0, SEL_STATUS}, 24'hffffe1);
		rd(SEL_STATUS, 24'h000001, "status mask");
		chk(te, 1'b1, "trace enable");
		wr({3'h0, SEL_STATUS}, 24'h000002);
		rd(SEL_STATUS, 24'h000002, "interrupt mode");
		chk(vo, 8'h06, "vector offset");
		core_set(5'b00010);
		core_set(5'b00000);
		wr({3'h0, SEL_STATUS}, 24'h0);
		chk(n_vi, 1, "vector pulse");
		for (int k = 0; k < 4; k++)
		begin
			core_set({k == 3, k == 1, k == 2, 2'b00});
			chk(cs, k[1:0], "core state");
		end
		core_set(5'b00010);
		core_set(5'b10010);
		rd(SEL_STATUS, 24'h0000c4, "software entry");
		wr(8'h41, 24'h001234);
		chk(n_go, 0, "go ignored");
		wr(8'h5f, 24'h0);
		chk({n_go[7:0], n_ex[7:0]}, 16'h0100, "go alone");
		wr(8'h6a, 24'h000777);
		chk({n_go[7:0], n_ex[7:0]}, 16'h0201, "go and exit");
		core_set(5'b00000);
		rd(SEL_STATUS, 24'h0, "flags cleared");
		$display("debug entry test done");
		// breakpoint 0 on a read or write of limit zero in space 1, count zero
		wr({3'h0, SEL_BP_CTL}, 24'h00041d);
		wr({3'h0, SEL_BP_CNT}, 24'h0);
		@(posedge clock_in);
		mem <= {1'b1, 2'h1, 1'b1, 1'b0, shadow[5][15:0]};
		@(posedge clock_in);
		mem <= '0;
		repeat (4) @(posedge clock_in);
		chk(dr, 1'b1, "breakpoint request");
		core_set(5'b10000);
		rd(SEL_STATUS, 24'h0000c8, "breakpoint entry");
		core_set(5'b00000);
		$display("breakpoint test done");
		wr({3'h0, SEL_STEP}, 24'h000002);
		wr({3'h0, SEL_STATUS}, 24'h000001);
		repeat (2)
		begin
			core_set(5'b00001);
			core_set(5'b00000);
		end
		chk(dr, 1'b1, "step request");
		rd(SEL_STEP, 24'h0, "step count");
		core_set(5'b10000);
		rd(SEL_STATUS, 24'h0000d1, "step entry");
		core_set(5'b00000);
		$display("step test done");
		finish_test();
	end
endmodule // tb_top
